//--- testbench/dnc_adc_model.sv
`timescale 1ns/10ps
`default_nettype none
// ========================================
// sample source and delayed reference
module dnc_adc_model (
  input wire logic clk,
  input wire logic rampOn,
  output logic [15:0] sampleI,
  output logic [15:0] sampleQ,
  output logic [15:0] refI,
  output logic [15:0] refQ
);
  logic [15:0] hI [0:15];
  logic [15:0] hQ [0:15];
  assign refI = hI[15];
  assign refQ = hQ[15];
  // quiet at power up
  initial begin
    sampleI = 16'h0000;
    sampleQ = 16'h0000;
    for (int k = 0; k < 16; k++) begin
      hI[k] = 16'h0000;
      hQ[k] = 16'h0000;
    end
  end
  // one sample per clock, history of what was taken
  always @(posedge clk) begin
    sampleI <= rampOn ? sampleI + 16'h0101 : 16'h0000;
    sampleQ <= rampOn ? sampleQ - 16'h0307 : 16'h0000;
    hI[0] <= sampleI;
    hQ[0] <= sampleQ;
    for (int k = 1; k < 16; k++) begin
      hI[k] <= hI[k-1];
      hQ[k] <= hQ[k-1];
    end
  end
endmodule
`default_nettype wire

//--- testbench/dnc_nco_mixer_assertions.sv
`timescale 1ns/10ps
`default_nettype none
`include "dnc_regs.svh"
// ========================================
// bus and datapath checks
module dnc_nco_mixer_assertions (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  input wire logic [31:0] avsReaddata,
  input wire logic avsWaitrequest,
  input wire logic [15:0] sampleI,
  input wire logic [15:0] sampleQ,
  input wire logic sysrefPin,
  input wire logic [3:0] gpioSelPin,
  input wire logic [15:0] mixI,
  input wire logic [15:0] mixQ
);
  logic [31:0] ctrl_r;
  logic [4:0] setl_r;
  logic [4:0] zero_r;
  wire logic rdTake = avsRead && avsWaitrequest;
  wire logic ctlWr = avsWrite && !avsWaitrequest && avsAddress == `DNC_OFS_CTRL;
  wire logic zIn = sampleI == 16'h0000 && sampleQ == 16'h0000;
  wire logic calm = setl_r == 5'h1f;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // control shadow, cycles since mode write, run of zero samples
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `DNC_CTRL_RST;
      setl_r <= 5'h00;
      zero_r <= 5'h00;
    end else begin
      ctrl_r <= ctlWr ? avsWritedata & `DNC_CTRL_MASK : ctrl_r;
      setl_r <= ctlWr ? 5'h00 : setl_r + {4'h0, !calm};
      zero_r <= !zIn ? 5'h00 : zero_r + {4'h0, zero_r != 5'h1f};
    end
  end
  sequence sTaken;
    (avsRead || avsWrite) && avsWaitrequest;
  endsequence
  sequence sAnswer;
    !avsWaitrequest ##1 avsWaitrequest;
  endsequence
  a_bus_answer: assert property (sTaken |=> sAnswer)
    else $error("bus answer not one cycle");
  a_wait_idle: assert property (avsWaitrequest && !avsRead && !avsWrite |=> avsWaitrequest)
    else $error("answer without request");
  a_read_held: assert property (!$stable(avsReaddata) |-> $past(rdTake))
    else $error("read data moved without read");
  a_unmapped_zero: assert property (rdTake && avsAddress > 8'h33 |=> avsReaddata == 32'h0)
    else $error("unmapped read not zero");
  a_hi_upper_zero: assert property (rdTake && avsAddress inside {8'h0c, 8'h14, 8'h1c,
    8'h24, 8'h30} |=> avsReaddata[31:16] == 16'h0000)
    else $error("upper half word not zero");
  a_ctrl_read: assert property (rdTake && avsAddress == 8'h00 |=> avsReaddata == ctrl_r)
    else $error("control readback wrong");
  a_zif_bypass: assert property (calm && ctrl_r[1:0] == 2'h1 |->
    mixI == $past(sampleI, 16) && mixQ == $past(sampleQ, 16))
    else $error("zero if output not delayed input");
  a_zero_mix: assert property (calm && ctrl_r[1:0] != 2'h3 && zero_r > 5'h10 |->
    mixI == 16'h0000 && mixQ == 16'h0000)
    else $error("zero input gave nonzero mix");
endmodule
bind dnc_nco_mixer dnc_nco_mixer_assertions i_chk (
  .clk, .rst_n, .avsAddress, .avsRead, .avsWrite, .avsWritedata, .avsReaddata,
  .avsWaitrequest, .sampleI, .sampleQ, .sysrefPin, .gpioSelPin, .mixI, .mixQ
);
`default_nettype wire

//--- testbench/dnc_nco_mixer_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "dnc_regs.svh"
// ========================================
// bench for oscillator and mixer
module dnc_nco_mixer_tb;
  typedef struct {
    logic [1:0] mode;
    dnc_pkg::dnc_word_t freq_tuning_word;
    dnc_pkg::dnc_word_t num;
    dnc_pkg::dnc_word_t den;
    logic [7:0] adr;
    logic [31:0] exp;
  } dnc_row_t;
  logic clk, rst_n, avsRead, avsWrite, avsWaitrequest, sysrefPin, rampOn;
  logic [7:0] avsAddress;
  logic [31:0] avsWritedata, avsReaddata, q, x, y;
  logic [15:0] sampleI, sampleQ, mixI, mixQ, refI, refQ;
  logic [3:0] gpioSelPin;
  int n_fail = 0;
  int n_checks = 0;
  dnc_row_t rows [7];
  dnc_nco_mixer i_dut (.clk, .rst_n, .avsAddress, .avsRead, .avsWrite, .avsWritedata,
    .avsReaddata, .avsWaitrequest, .sampleI, .sampleQ, .sysrefPin, .gpioSelPin, .mixI, .mixQ);
  dnc_adc_model i_adc (.clk, .rampOn, .sampleI, .sampleQ, .refI, .refQ);
  // 50 MHz clock
  initial begin
    clk = 1'h0;
    forever #10 clk = ~clk;
  end
  // ========================================
  // tasks
  task automatic end_sim;
    $display("checks %0d, failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h, expected %h", $time, g, e);
    end
  endtask
  task automatic near(input logic [15:0] g, input logic [15:0] e, input logic [15:0] t);
    logic [15:0] d;
    d = g - e + t;
    chk({16'h0, d <= t + t ? e : g}, {16'h0, e});
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int k;
    k = 0;
    avsAddress <= a;
    avsWritedata <= d;
    avsWrite <= w;
    avsRead <= !w;
    do begin
      @(posedge clk);
      k++;
    end while (avsWaitrequest !== 1'h0 && k < 50);
    r = avsReaddata;
    avsWrite <= 1'h0;
    avsRead <= 1'h0;
    if (avsWaitrequest !== 1'h0) begin
      n_fail++;
      end_sim;
    end
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'h1, a, d, r);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    bus(1'h0, a, 32'h0, r);
  endtask
  task automatic w48(input logic [7:0] a, input dnc_pkg::dnc_word_t v);
    wr(a, v[31:0]);
    wr(a + 8'h04, {16'h0000, v[47:32]});
  endtask
  task automatic sync(input logic [31:0] c);
    wr(`DNC_OFS_CTRL, c | 32'h10);
    wr(`DNC_OFS_CTRL, c);
  endtask
  task automatic mixRun(input logic [31:0] c, input logic qt, input logic [15:0] t);
    sync(c);
    repeat (36) @(posedge clk);
    repeat (16) begin
      @(posedge clk);
      near(mixI, qt ? refQ : refI, t);
      near(mixQ, qt ? 16'h0000 - refI : refQ, t);
    end
  endtask
  // ========================================
  // main sequence
  initial begin
    rst_n = 1'h0;
    avsRead = 1'h0;
    avsWrite = 1'h0;
    avsAddress = 8'h00;
    avsWritedata = 32'h0;
    sysrefPin = 1'h0;
    gpioSelPin = 4'h0;
    rampOn = 1'h0;
    rows[0] = '{2'h0, 48'h8000_0000_0000, 48'h0, 48'h1, `DNC_OFS_PAW_HI, 32'h8000};
    rows[1] = '{2'h0, 48'hffff_ffff_ffff, 48'h0, 48'h1, `DNC_OFS_PAW_LO, 32'hffff_fffd};
    rows[2] = '{2'h0, 48'h1234, 48'h0, 48'h1, `DNC_OFS_PAW_LO, 32'h369c};
    rows[3] = '{2'h2, 48'h1234, 48'h0, 48'h1, `DNC_OFS_PAW_HI, 32'hc000};
    rows[4] = '{2'h1, 48'h1234, 48'h0, 48'h1, `DNC_OFS_PAW_LO, 32'h0};
    rows[5] = '{2'h0, 48'h0, 48'h2, 48'h3, `DNC_OFS_PAW_LO, 32'h2};
    rows[6] = '{2'h0, 48'h10, 48'h1, 48'h3, `DNC_OFS_PAW_LO, 32'h31};
    repeat (10) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    // accumulator step per case, sampled three cycles apart
    foreach (rows[i]) begin
      wr(`DNC_OFS_CHIDX, 32'h0);
      w48(`DNC_OFS_FTW_LO, rows[i].freq_tuning_word);
      w48(`DNC_OFS_MNUM_LO, rows[i].num);
      w48(`DNC_OFS_MDEN_LO, rows[i].den);
      sync({30'h0, rows[i].mode});
      rd(rows[i].adr, x);
      rd(rows[i].adr, y);
      q = y - x;
      if (rows[i].adr == `DNC_OFS_PAW_HI) q[31:16] = 16'h0000;
      chk(q, rows[i].exp);
    end
    // soft reset holds accumulators at zero
    wr(`DNC_OFS_CTRL, 32'h10);
    rd(`DNC_OFS_PAW_LO, q);
    chk(q, 32'h0);
    // hop between two slots keeps common time base
    w48(`DNC_OFS_MNUM_LO, 48'h0);
    wr(`DNC_OFS_CHIDX, 32'h1);
    w48(`DNC_OFS_FTW_LO, 48'h2468);
    wr(`DNC_OFS_CHIDX, 32'h0);
    w48(`DNC_OFS_FTW_LO, 48'h1234);
    sync(32'h0);
    rd(`DNC_OFS_PAW_LO, x);
    wr(`DNC_OFS_CTRL, 32'h100);
    rd(`DNC_OFS_PAW_LO, y);
    chk(y, 2 * x + 32'hda70);
    // sync pin clears a running accumulator
    wr(`DNC_OFS_CTRL, 32'h120);
    repeat (40) @(posedge clk);
    sysrefPin <= 1'h1;
    repeat (6) @(posedge clk);
    rd(`DNC_OFS_PAW_LO, q);
    sysrefPin <= 1'h0;
    chk({31'h0, q < 32'h0002_4680}, 32'h1);
    // slot chosen by pins
    gpioSelPin <= 4'h5;
    wr(`DNC_OFS_CTRL, 32'h1000);
    repeat (4) @(posedge clk);
    rd(`DNC_OFS_STATUS, q);
    chk(q & 32'h0000_f047, 32'h0000_5000);
    // mixer: phase zero, quarter turn offset, bypass
    wr(`DNC_OFS_CTRL, 32'h0);
    w48(`DNC_OFS_FTW_LO, 48'h0);
    rampOn <= 1'h1;
    mixRun(32'h0, 1'h0, 16'h0010);
    w48(`DNC_OFS_POW_LO, 48'h4000_0000_0000);
    mixRun(32'h0, 1'h1, 16'h0010);
    mixRun(32'h1, 1'h0, 16'h0000);
    // test mode: full-scale input turned a quarter
    sync(32'h3);
    repeat (36) @(posedge clk);
    near(mixI, 16'h7fff, 16'h0010);
    near(mixQ, 16'h8001, 16'h0010);
    // unmapped place, writable mask, second reset
    rampOn <= 1'h0;
    rd(8'h3c, q);
    chk(q, 32'h0);
    wr(`DNC_OFS_CTRL, 32'hffff_ffff);
    rd(`DNC_OFS_CTRL, q);
    chk(q, `DNC_CTRL_MASK);
    rst_n <= 1'h0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    @(posedge clk);
    rd(`DNC_OFS_CTRL, q);
    chk(q, 32'h0);
    rd(`DNC_OFS_MDEN_LO, q);
    chk(q, 32'h1);
    rd(`DNC_OFS_FTW_LO, q);
    chk(q, 32'h0);
    end_sim;
  end
endmodule
`default_nettype wire

//--- verilog/dnc_nco_mixer.sv
// Design decisions made here: the register offsets and register access over Avalon-MM.
`timescale 1ns/10ps
`default_nettype none
`include "dnc_regs.svh"
module dnc_nco_mixer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWritedata,
  output logic [31:0] avsReaddata,
  output logic avsWaitrequest,
  input wire logic [15:0] sampleI,
  input wire logic [15:0] sampleQ,
  input wire logic sysrefPin,
  input wire logic [3:0] gpioSelPin,
  output logic [15:0] mixI,
  output logic [15:0] mixQ
);
  localparam int LAT = `DNC_CORDIC_LAT;

  // ==========================================================
  // bus slave handshake
  logic waitReq_r;
  logic [31:0] rdData_r;
  logic [31:0] ctrl_r;
  logic [3:0] chIdx_r;
  dnc_pkg::dnc_word_t mNum_r;
  dnc_pkg::dnc_word_t mDen_r;
  dnc_pkg::dnc_word_t frac_r;
  dnc_pkg::dnc_word_t ftw_r [0:15];
  dnc_pkg::dnc_word_t pow_r [0:15];
  dnc_pkg::dnc_word_t acc_r [0:15];

  // request seen while waitrequest high, taken at the next edge
  // one wait cycle per access keeps every answer from a flop
  wire reqNew = (avsRead || avsWrite) && waitReq_r;
  wire wrEn = avsWrite && !waitReq_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      waitReq_r <= 1'b1;
    end else begin
      waitReq_r <= !reqNew;
    end
  end
  assign avsWaitrequest = waitReq_r;

  // ==========================================================
  // address decode
  wire wrCtrl = wrEn && (avsAddress == `DNC_OFS_CTRL);
  wire wrChIdx = wrEn && (avsAddress == `DNC_OFS_CHIDX);
  wire wrFtwLo = wrEn && (avsAddress == `DNC_OFS_FTW_LO);
  wire wrFtwHi = wrEn && (avsAddress == `DNC_OFS_FTW_HI);
  wire wrPowLo = wrEn && (avsAddress == `DNC_OFS_POW_LO);
  wire wrPowHi = wrEn && (avsAddress == `DNC_OFS_POW_HI);
  wire wrNumLo = wrEn && (avsAddress == `DNC_OFS_MNUM_LO);
  wire wrNumHi = wrEn && (avsAddress == `DNC_OFS_MNUM_HI);
  wire wrDenLo = wrEn && (avsAddress == `DNC_OFS_MDEN_LO);
  wire wrDenHi = wrEn && (avsAddress == `DNC_OFS_MDEN_HI);

  // ==========================================================
  // control fields
  wire [1:0] modeBits = ctrl_r[`DNC_CTRL_MODE_LSB +: 2];
  wire dnc_pkg::dnc_if_mode_t ifMode = dnc_pkg::dnc_if_mode_t'(modeBits);
  wire softRst = ctrl_r[`DNC_CTRL_SRST_BIT];
  wire sysrefEn = ctrl_r[`DNC_CTRL_SYSEN_BIT];
  wire [3:0] regChan = ctrl_r[`DNC_CTRL_CHAN_LSB +: 4];
  wire gpioEn = ctrl_r[`DNC_CTRL_GPIOEN_BIT];
  wire zeroIf = (ifMode == dnc_pkg::IF_ZERO);
  // fs/4 uses a fixed step, test mode a fixed input
  wire fs4Mode = (ifMode == dnc_pkg::IF_FS4);
  wire testMode = (ifMode == dnc_pkg::IF_TEST);

  // ==========================================================
  // pin synchronisers
  logic [1:0] sysrefSync_r;
  logic sysrefPrev_r;
  logic [3:0] gpioMeta_r;
  logic [3:0] gpioSync_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sysrefSync_r <= 2'h0;
      sysrefPrev_r <= 1'b0;
      gpioMeta_r <= 4'h0;
      gpioSync_r <= 4'h0;
    end else begin
      sysrefSync_r <= {sysrefSync_r[0], sysrefPin};
      sysrefPrev_r <= sysrefSync_r[1];
      gpioMeta_r <= gpioSelPin;
      gpioSync_r <= gpioMeta_r;
    end
  end
  wire sysrefRise = sysrefSync_r[1] && !sysrefPrev_r;

  // accumulators cleared by soft reset, sysref event or zero IF
  // sysref acts only through its synchronised rising edge
  wire syncClr = softRst || (sysrefEn && sysrefRise) || zeroIf;
  wire [3:0] selChan = gpioEn ? gpioSync_r : regChan;

  // ==========================================================
  // configuration registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_r <= `DNC_CTRL_RST;
      chIdx_r <= 4'h0;
    end else begin
      if (wrCtrl) ctrl_r <= avsWritedata & `DNC_CTRL_MASK;
      if (wrChIdx) chIdx_r <= avsWritedata[3:0];
    end
  end

  // new modulus words take effect at once, with no resync
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mNum_r <= `DNC_WORD_RST;
      mDen_r <= `DNC_MDEN_RST;
    end else begin
      if (wrNumLo) mNum_r[31:0] <= avsWritedata;
      if (wrNumHi) mNum_r[47:32] <= avsWritedata[15:0];
      if (wrDenLo) mDen_r[31:0] <= avsWritedata;
      if (wrDenHi) mDen_r[47:32] <= avsWritedata[15:0];
    end
  end

  // ==========================================================
  // modulus fraction accumulator, unsigned compare
  // 49-bit sum so a total past 2^48 still compares right
  wire modActive = (mNum_r != `DNC_WORD_RST);
  wire [48:0] fracSum = {1'b0, frac_r} + {1'b0, mNum_r};
  wire fracWrap = modActive && (fracSum >= {1'b0, mDen_r});
  wire [48:0] fracRem = fracSum - {1'b0, mDen_r};
  wire [47:0] fracNxt = fracWrap ? fracRem[47:0] : fracSum[47:0];
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      frac_r <= `DNC_WORD_RST;
    end else begin
      frac_r <= (syncClr || !modActive) ? `DNC_WORD_RST : fracNxt;
    end
  end
  // one extra phase lsb on each fraction wrap
  wire [47:0] carryLsb = {47'h0, fracWrap};

  // ==========================================================
  // shadow slots, each with its own running accumulator
  genvar k;
  generate
    for (k = 0; k < 16; k++) begin : g_slot
      wire hit = (chIdx_r == 4'(k));
      wire [47:0] step = fs4Mode ? `DNC_FS4_FTW : ftw_r[k];
      // words written here never disturb the accumulators
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          ftw_r[k] <= `DNC_WORD_RST;
          pow_r[k] <= `DNC_WORD_RST;
        end else begin
          if (wrFtwLo && hit) ftw_r[k][31:0] <= avsWritedata;
          if (wrFtwHi && hit) ftw_r[k][47:32] <= avsWritedata[15:0];
          if (wrPowLo && hit) pow_r[k][31:0] <= avsWritedata;
          if (wrPowHi && hit) pow_r[k][47:32] <= avsWritedata[15:0];
        end
      end
      // every slot runs from the same sync, so hops stay coherent
      // a clear in the same cycle as a step wins
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          acc_r[k] <= `DNC_WORD_RST;
        end else begin
          acc_r[k] <= syncClr ? `DNC_WORD_RST : acc_r[k] + step + carryLsb;
        end
      end
    end
  endgenerate

  // ==========================================================
  // active phase: accumulator plus offset, wraps mod 2^48
  wire [47:0] phaseSel = acc_r[selChan] + pow_r[selChan];
  // only the top 16 phase bits reach the sine and cosine stage
  dnc_sincos_if trig ();
  assign trig.angle = phaseSel[47:32];
  dnc_sincos u_sincos (
    .clk(clk),
    .rst_n(rst_n),
    .io(trig)
  );

  // ==========================================================
  // sample delay line matching the sine/cosine pipeline
  wire [15:0] inI = testMode ? 16'h7fff : sampleI;
  wire [15:0] inQ = testMode ? 16'h7fff : sampleQ;
  logic [15:0] dlyI_r [0:LAT-1];
  logic [15:0] dlyQ_r [0:LAT-1];
  genvar d;
  generate
    for (d = 0; d < LAT; d++) begin : g_dly
      wire [15:0] srcI = (d == 0) ? inI : dlyI_r[(d == 0) ? 0 : d-1];
      wire [15:0] srcQ = (d == 0) ? inQ : dlyQ_r[(d == 0) ? 0 : d-1];
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          dlyI_r[d] <= 16'h0000;
          dlyQ_r[d] <= 16'h0000;
        end else begin
          dlyI_r[d] <= srcI;
          dlyQ_r[d] <= srcQ;
        end
      end
    end
  endgenerate

  // ==========================================================
  // complex mixer: (I + jQ)(cos - j sin)
  // saturate, since near full scale a wrapped sum flips sign
  function automatic logic [15:0] sat16(input logic signed [34:0] v);
    logic allSame;
    allSame = (v[34:30] == 5'h00) || (v[34:30] == 5'h1f);
    sat16 = allSame ? v[30:15] : (v[34] ? 16'h8000 : 16'h7fff);
  endfunction

  // delayed sample times the matching cosine and sine
  wire signed [15:0] dI = dlyI_r[LAT-1];
  wire signed [15:0] dQ = dlyQ_r[LAT-1];
  wire signed [33:0] pIc = dI * trig.cosVal;
  wire signed [33:0] pIs = dI * trig.sinVal;
  wire signed [33:0] pQc = dQ * trig.cosVal;
  wire signed [33:0] pQs = dQ * trig.sinVal;
  wire signed [34:0] sumI = 35'(pIc) + 35'(pQs);
  wire signed [34:0] sumQ = 35'(pQc) - 35'(pIs);
  wire [15:0] mixINxt = zeroIf ? dI : sat16(sumI);
  wire [15:0] mixQNxt = zeroIf ? dQ : sat16(sumQ);
  // output registers, zero IF passes the delayed sample
  logic [15:0] mixI_r;
  logic [15:0] mixQ_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mixI_r <= 16'h0000;
      mixQ_r <= 16'h0000;
    end else begin
      mixI_r <= mixINxt;
      mixQ_r <= mixQNxt;
    end
  end
  assign mixI = mixI_r;
  assign mixQ = mixQ_r;

  // ==========================================================
  // read mux, unmapped offsets read zero
  wire [15:0] statusLo = {selChan, 5'h00, modActive, 3'h0, zeroIf, modeBits};
  wire [31:0] statusWord = {16'h0000, statusLo};
  wire [31:0] rdMux =
    (avsAddress == `DNC_OFS_CTRL) ? ctrl_r :
    (avsAddress == `DNC_OFS_CHIDX) ? {28'h0, chIdx_r} :
    (avsAddress == `DNC_OFS_FTW_LO) ? ftw_r[chIdx_r][31:0] :
    (avsAddress == `DNC_OFS_FTW_HI) ? {16'h0, ftw_r[chIdx_r][47:32]} :
    (avsAddress == `DNC_OFS_POW_LO) ? pow_r[chIdx_r][31:0] :
    (avsAddress == `DNC_OFS_POW_HI) ? {16'h0, pow_r[chIdx_r][47:32]} :
    (avsAddress == `DNC_OFS_MNUM_LO) ? mNum_r[31:0] :
    (avsAddress == `DNC_OFS_MNUM_HI) ? {16'h0, mNum_r[47:32]} :
    (avsAddress == `DNC_OFS_MDEN_LO) ? mDen_r[31:0] :
    (avsAddress == `DNC_OFS_MDEN_HI) ? {16'h0, mDen_r[47:32]} :
    (avsAddress == `DNC_OFS_STATUS) ? statusWord :
    (avsAddress == `DNC_OFS_PAW_LO) ? acc_r[selChan][31:0] :
    (avsAddress == `DNC_OFS_PAW_HI) ? {16'h0, acc_r[selChan][47:32]} :
    32'h0000_0000;

  // read data captured with the request, stands at the answer edge
  // a later write cannot disturb it until the next read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdData_r <= 32'h0000_0000;
    end else if (reqNew && avsRead) begin
      rdData_r <= rdMux;
    end
  end
  assign avsReaddata = rdData_r;
endmodule
`default_nettype wire

//--- verilog/dnc_pkg.sv
`default_nettype none
package dnc_pkg;
  // frequency translation modes, in control field order
  typedef enum logic [1:0] {IF_VARIABLE, IF_ZERO, IF_FS4, IF_TEST} dnc_if_mode_t;
  typedef logic [47:0] dnc_word_t;
  typedef logic signed [17:0] dnc_trig_t;
endpackage
`default_nettype wire

//--- verilog/dnc_regs.svh
`ifndef DNC_REGS_SVH
`define DNC_REGS_SVH

// ==========================================================
// register byte offsets
`define DNC_OFS_CTRL 8'h00
`define DNC_OFS_CHIDX 8'h04
`define DNC_OFS_FTW_LO 8'h08
`define DNC_OFS_FTW_HI 8'h0c
`define DNC_OFS_POW_LO 8'h10
`define DNC_OFS_POW_HI 8'h14
`define DNC_OFS_MNUM_LO 8'h18
`define DNC_OFS_MNUM_HI 8'h1c
`define DNC_OFS_MDEN_LO 8'h20
`define DNC_OFS_MDEN_HI 8'h24
`define DNC_OFS_STATUS 8'h28
`define DNC_OFS_PAW_LO 8'h2c
`define DNC_OFS_PAW_HI 8'h30

// ==========================================================
// control register fields
`define DNC_CTRL_MODE_LSB 0
`define DNC_CTRL_SRST_BIT 4
`define DNC_CTRL_SYSEN_BIT 5
`define DNC_CTRL_CHAN_LSB 8
`define DNC_CTRL_GPIOEN_BIT 12
`define DNC_CTRL_MASK 32'h0000_1f33

// ==========================================================
// reset values
`define DNC_CTRL_RST 32'h0000_0000
`define DNC_WORD_RST 48'h0000_0000_0000
`define DNC_MDEN_RST 48'h0000_0000_0001

// ==========================================================
// oscillator constants
`define DNC_FS4_FTW 48'h4000_0000_0000
`define DNC_CORDIC_K 18'h04dba
`define DNC_CORDIC_STAGES 14
`define DNC_CORDIC_LAT 15

`endif

//--- verilog/dnc_sincos.sv
`timescale 1ns/10ps
`default_nettype none
`include "dnc_regs.svh"
module dnc_sincos (
  input wire logic clk,
  input wire logic rst_n,
  dnc_sincos_if.gen io
);
  // arctangent of 2^-i in units of 1/65536 turn
  localparam logic signed [16:0] ATAN [0:13] = '{
    17'h02000, 17'h012e4, 17'h009fb, 17'h00511, 17'h0028b, 17'h00146, 17'h000a3,
    17'h00051, 17'h00029, 17'h00014, 17'h0000a, 17'h00005, 17'h00003, 17'h00001};

  logic signed [17:0] x_r [0:`DNC_CORDIC_STAGES];
  logic signed [17:0] y_r [0:`DNC_CORDIC_STAGES];
  logic signed [16:0] z_r [0:`DNC_CORDIC_STAGES];

  // ==========================================================
  // quadrant fold: start vector placed on an axis
  wire [1:0] quad = io.angle[15:14];
  wire signed [17:0] kPos = `DNC_CORDIC_K;
  wire signed [17:0] kNeg = -kPos;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      x_r[0] <= 18'h00000;
      y_r[0] <= 18'h00000;
      z_r[0] <= 17'h00000;
    end else begin
      x_r[0] <= (quad == 2'h0) ? kPos : (quad == 2'h2) ? kNeg : 18'h00000;
      y_r[0] <= (quad == 2'h1) ? kPos : (quad == 2'h3) ? kNeg : 18'h00000;
      z_r[0] <= {3'h0, io.angle[13:0]};
    end
  end

  // ==========================================================
  // rotation stages, one per iteration
  genvar i;
  generate
    for (i = 0; i < `DNC_CORDIC_STAGES; i++) begin : g_stage
      wire signed [17:0] xs = x_r[i] >>> i;
      wire signed [17:0] ys = y_r[i] >>> i;
      wire dirPos = !z_r[i][16];
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          x_r[i+1] <= 18'h00000;
          y_r[i+1] <= 18'h00000;
          z_r[i+1] <= 17'h00000;
        end else begin
          x_r[i+1] <= dirPos ? x_r[i] - ys : x_r[i] + ys;
          y_r[i+1] <= dirPos ? y_r[i] + xs : y_r[i] - xs;
          z_r[i+1] <= dirPos ? z_r[i] - ATAN[i] : z_r[i] + ATAN[i];
        end
      end
    end
  endgenerate

  assign io.cosVal = x_r[`DNC_CORDIC_STAGES];
  assign io.sinVal = y_r[`DNC_CORDIC_STAGES];
endmodule
`default_nettype wire

//--- verilog/dnc_sincos_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dnc_sincos_if;
  logic [15:0] angle;
  dnc_pkg::dnc_trig_t cosVal;
  dnc_pkg::dnc_trig_t sinVal;
  modport gen (input angle, output cosVal, output sinVal);
  modport user (output angle, input cosVal, input sinVal);
endinterface
`default_nettype wire
